// ---- hw/aemc_regs.svh ----
// Offsets, field positions, reset values for the error mask/control/log bank
//
// Summary of operation
// - The advisory nonfatal mask bit 13 resets to one and is read/write.
// - Mask bits 12, 8, 7, 6 and 0 are read/write; 0 unmasks, 1 masks.
// - Reserved bits of the mask and capability/control registers read zero.
// - Capability/control bit 8 is the read/write extended CRC check enable.
// - Capability/control bit 7 is read-only and always reads one.
// - Capability/control bit 6 is the read/write extended CRC generate enable.
// - Capability/control bit 5 is read-only and always reads one.
// - Bits 4:0 are a hardware-loaded pointer to the first uncorrectable error.
// - Every unmasked correctable error and every uncorrectable log request captures the offending header into the log.
// - Log doubleword 0 sits at 11Ch and doubleword 3 at 128h, in order.
// - The log is read-only to software and resets to all zeros.
// - The capability/control register reads 0000_00A0h after reset.
// - A masked correctable error still sets status but is neither logged
//       nor reported upstream.
`ifndef AEMC_REGS_SVH
`define AEMC_REGS_SVH

// ---------------------------------------------------------------------------
// Configuration space offsets (byte addresses)
// ---------------------------------------------------------------------------
`define AEMC_CORR_MASK_OFS 12'h114
`define AEMC_CAP_CTRL_OFS 12'h118
`define AEMC_HDR_LOG0_OFS 12'h11C
`define AEMC_HDR_LOG3_OFS 12'h128

// ---------------------------------------------------------------------------
// Correctable mask fields
// ---------------------------------------------------------------------------
`define AEMC_MSK_RX_ERR 0
`define AEMC_MSK_BAD_TLP 6
`define AEMC_MSK_BAD_DLLP 7
`define AEMC_MSK_REPLAY_ROLL 8
`define AEMC_MSK_REPLAY_TMOUT 12
`define AEMC_MSK_ADVISORY 13
`define AEMC_CORR_MASK_WR 32'h0000_31C1
`define AEMC_CORR_MASK_RST 32'h0000_2000

// ---------------------------------------------------------------------------
// Capability and control fields
// ---------------------------------------------------------------------------
`define AEMC_CHK_EN_BIT 8
`define AEMC_CHK_CAP_BIT 7
`define AEMC_GEN_EN_BIT 6
`define AEMC_GEN_CAP_BIT 5
`define AEMC_PTR_MSB 4
`define AEMC_CAP_CTRL_RST 32'h0000_00A0
`define AEMC_HDR_LOG_RST 32'h0000_0000

`endif

// ---- hw/aemc_pkg.sv ----
// Shared types of the error mask/control/log bank
package aemc_pkg;
	typedef logic [31:0] aemc_dword_t;
	typedef logic [11:0] aemc_addr_t;
	typedef logic [4:0] aemc_ptr_t;
	typedef logic [1:0] aemc_dw_idx_t;
endpackage : aemc_pkg

// ---- hw/aemc_mask_gate.sv ----
// Per-error gating of correctable events by their mask bits
module aemc_mask_gate #(
	parameter int NUM_ERR = 6
) (
	// Event pulses and masks, same bit order
	input wire logic [NUM_ERR-1:0] err_i,
	input wire logic [NUM_ERR-1:0] mask_i,
	// Events allowed to log and report
	output logic [NUM_ERR-1:0] report_o,
	output logic any_report_o
);

	// ---------------------------------------------------------------------
	// Gating
	// ---------------------------------------------------------------------
	// One gate per error source
	genvar g;
	generate
		for (g = 0; g < NUM_ERR; g++)
		begin : g_gate
			assign report_o[g] = err_i[g] & ~mask_i[g];
		end
	endgenerate

	assign any_report_o = |report_o;

endmodule : aemc_mask_gate

// ---- hw/aemc_header_log.sv ----
// Four-doubleword header log, loaded only by hardware
`include "aemc_regs.svh"
module aemc_header_log (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Capture side
	input wire logic capture_i,
	input wire logic [127:0] hdr_i,
	// Read side
	input wire aemc_pkg::aemc_dw_idx_t rd_idx_i,
	output aemc_pkg::aemc_dword_t rd_data_o
);

	// ---------------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------------
	aemc_pkg::aemc_dword_t log_q [4];

	// Capture most recent offender; no software write path exists
	always_ff @(posedge core_clk_i)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (rst_i)
				log_q[i] <= `AEMC_HDR_LOG_RST;
			else if (capture_i)
				log_q[i] <= hdr_i[32*i +: 32];
		end
	end

	assign rd_data_o = log_q[rd_idx_i];

	// ---------------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------------
	hdr_capture_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		capture_i |=>
		{log_q[3], log_q[2], log_q[1], log_q[0]} == $past(hdr_i))
		else $error("header log missed a capture");
	hdr_hold_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!capture_i |=> $stable(log_q[0]) && $stable(log_q[1]) &&
		$stable(log_q[2]) && $stable(log_q[3]))
		else $error("header log changed without capture");

endmodule : aemc_header_log

// ---- hw/aemc_aer_regs.sv ----
// Correctable mask, capability/control and header log register bank
`include "aemc_regs.svh"
module aemc_aer_regs #(
	parameter int NUM_CORR = 6
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Configuration access port
	input wire aemc_pkg::aemc_addr_t cfg_addr_i,
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire logic [3:0] cfg_be_i,
	input wire aemc_pkg::aemc_dword_t cfg_wdata_i,
	output aemc_pkg::aemc_dword_t cfg_rdata_o,
	output logic cfg_rvalid_o,
	// Correctable error events from link and physical layers
	input wire logic [NUM_CORR-1:0] corr_err_i,
	// Uncorrectable error log request and header of offender
	input wire logic unc_log_i,
	input wire logic [127:0] err_hdr_i,
	// First-error pointer load from uncorrectable status logic
	input wire logic first_err_load_i,
	input wire aemc_pkg::aemc_ptr_t first_err_pos_i,
	// Status set pulses and reportable events
	output logic [NUM_CORR-1:0] corr_status_set_o,
	output logic [NUM_CORR-1:0] corr_report_o,
	// Extended CRC enables to the transaction layer
	output logic end_crc_check_enable_o,
	output logic end_crc_generate_enable_o
);

	// ---------------------------------------------------------------------
	// Byte-enable merge
	// ---------------------------------------------------------------------
	// Merges write data into old value under byte enables and writable bits
	function automatic aemc_pkg::aemc_dword_t be_merge(
		input aemc_pkg::aemc_dword_t old_v,
		input aemc_pkg::aemc_dword_t new_v,
		input logic [3:0] be,
		input aemc_pkg::aemc_dword_t wr_bits
	);
		aemc_pkg::aemc_dword_t lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		lane = lane & wr_bits;
		return (old_v & ~lane) | (new_v & lane);
	endfunction : be_merge

	// ---------------------------------------------------------------------
	// State
	// ---------------------------------------------------------------------
	aemc_pkg::aemc_dword_t corr_mask;
	logic check_en;
	logic gen_en;
	aemc_pkg::aemc_ptr_t first_ptr;

	// ---------------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------------
	// Register hits, dword aligned
	wire hit_mask = cfg_addr_i == `AEMC_CORR_MASK_OFS;
	wire hit_cap = cfg_addr_i == `AEMC_CAP_CTRL_OFS;
	wire hit_log = cfg_addr_i >= `AEMC_HDR_LOG0_OFS &&
		cfg_addr_i <= `AEMC_HDR_LOG3_OFS &&
		cfg_addr_i[1:0] == 2'h0;
	wire wr_mask = cfg_wr_i & hit_mask;
	wire wr_cap = cfg_wr_i & hit_cap;
	wire [11:0] log_ofs = cfg_addr_i - `AEMC_HDR_LOG0_OFS;
	wire aemc_pkg::aemc_dw_idx_t log_idx = log_ofs[3:2];

	// ---------------------------------------------------------------------
	// Mask gating and log capture
	// ---------------------------------------------------------------------
	// Mask bits reordered to event order
	wire [NUM_CORR-1:0] mask_vec = {
		corr_mask[`AEMC_MSK_ADVISORY],
		corr_mask[`AEMC_MSK_REPLAY_TMOUT],
		corr_mask[`AEMC_MSK_REPLAY_ROLL],
		corr_mask[`AEMC_MSK_BAD_DLLP],
		corr_mask[`AEMC_MSK_BAD_TLP],
		corr_mask[`AEMC_MSK_RX_ERR]
	};
	wire [NUM_CORR-1:0] report_w;
	wire any_report_w;
	wire log_capture = unc_log_i | any_report_w;
	wire aemc_pkg::aemc_dword_t log_dword;

	aemc_mask_gate #(
		.NUM_ERR(NUM_CORR)
	) u_gate (
		.err_i(corr_err_i),
		.mask_i(mask_vec),
		.report_o(report_w),
		.any_report_o(any_report_w)
	);

	aemc_header_log u_log (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.capture_i(log_capture),
		.hdr_i(err_hdr_i),
		.rd_idx_i(log_idx),
		.rd_data_o(log_dword)
	);

	// ---------------------------------------------------------------------
	// Next values
	// ---------------------------------------------------------------------
	// Capability/control image with fixed flags and reserved zeros
	wire aemc_pkg::aemc_dword_t cap_image = {
		23'h000000,
		check_en,
		1'b1,
		gen_en,
		1'b1,
		first_ptr
	};
	wire aemc_pkg::aemc_dword_t next_mask = wr_mask ?
		be_merge(corr_mask, cfg_wdata_i, cfg_be_i, `AEMC_CORR_MASK_WR) :
		corr_mask;
	wire next_check_en = (wr_cap & cfg_be_i[1]) ?
		cfg_wdata_i[`AEMC_CHK_EN_BIT] : check_en;
	wire next_gen_en = (wr_cap & cfg_be_i[0]) ?
		cfg_wdata_i[`AEMC_GEN_EN_BIT] : gen_en;
	wire aemc_pkg::aemc_ptr_t next_ptr = first_err_load_i ?
		first_err_pos_i : first_ptr;
	// Read data mux; unmapped addresses and cycles without a read give zero
	wire aemc_pkg::aemc_dword_t next_rdata =
		!cfg_rd_i ? 32'h0000_0000 :
		hit_mask ? corr_mask :
		hit_cap ? cap_image :
		hit_log ? log_dword : 32'h0000_0000;

	// ---------------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------------
	// Software-written fields and hardware pointer
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			corr_mask <= `AEMC_CORR_MASK_RST;
			check_en <= 1'b0;
			gen_en <= 1'b0;
			first_ptr <= 5'h00;
		end
		else
		begin
			corr_mask <= next_mask;
			check_en <= next_check_en;
			gen_en <= next_gen_en;
			first_ptr <= next_ptr;
		end
	end

	// ---------------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------------
	// Read answer one cycle after request; event outputs registered
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			cfg_rdata_o <= 32'h0000_0000;
			cfg_rvalid_o <= 1'b0;
			corr_status_set_o <= '0;
			corr_report_o <= '0;
			end_crc_check_enable_o <= 1'b0;
			end_crc_generate_enable_o <= 1'b0;
		end
		else
		begin
			cfg_rdata_o <= next_rdata;
			cfg_rvalid_o <= cfg_rd_i;
			corr_status_set_o <= corr_err_i;
			corr_report_o <= report_w;
			end_crc_check_enable_o <= next_check_en;
			end_crc_generate_enable_o <= next_gen_en;
		end
	end

	// ---------------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------------
	mask_reset_a: assert property (@(posedge core_clk_i)
		rst_i |=> corr_mask == `AEMC_CORR_MASK_RST)
		else $error("mask reset value wrong");

	mask_write_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		cfg_wr_i && hit_mask && cfg_be_i == 4'hF |=>
		corr_mask == ($past(cfg_wdata_i) & `AEMC_CORR_MASK_WR))
		else $error("mask write not stored");

	rsvd_zero_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		cfg_rd_i && (hit_mask || hit_cap) |=>
		(cfg_rdata_o & ~`AEMC_CORR_MASK_WR & 32'hFFFF_FE00) == 32'h0)
		else $error("reserved bits read nonzero");

	check_en_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		wr_cap && cfg_be_i[1] |=>
		end_crc_check_enable_o == $past(cfg_wdata_i[`AEMC_CHK_EN_BIT]))
		else $error("check enable not written");

	cap_flags_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		cfg_rd_i && hit_cap |=>
		cfg_rdata_o[`AEMC_CHK_CAP_BIT] && cfg_rdata_o[`AEMC_GEN_CAP_BIT])
		else $error("capability flag reads zero");

	gen_en_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		wr_cap && cfg_be_i[0] |=> end_crc_generate_enable_o ==
		$past(cfg_wdata_i[`AEMC_GEN_EN_BIT]))
		else $error("generate enable not written");

	ptr_load_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		first_err_load_i |=> first_ptr == $past(first_err_pos_i))
		else $error("first error pointer not loaded");

	log_read_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		cfg_rd_i && cfg_addr_i == `AEMC_HDR_LOG3_OFS |=>
		cfg_rdata_o == $past(u_log.log_q[3]))
		else $error("log doubleword read from wrong slot");

	cap_reset_a: assert property (@(posedge core_clk_i)
		rst_i |=> cap_image == `AEMC_CAP_CTRL_RST)
		else $error("capability register reset value wrong");

	masked_silent_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		corr_err_i[0] && corr_mask[`AEMC_MSK_RX_ERR] |=>
		!corr_report_o[0] && corr_status_set_o[0])
		else $error("masked error reported or status lost");

	// Read answer follows its request by exactly one cycle
	rd_answer_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		cfg_rd_i |=> cfg_rvalid_o)
		else $error("read answer missing");

	// No answer and zero data when nothing was asked
	rvalid_pulse_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!cfg_rd_i |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000)
		else $error("read answer without request");

	// ---------------------------------------------------------------------
	// Hold and decode checks
	// ---------------------------------------------------------------------
	// Reserved mask bits can never be stored
	mask_rsvd_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(corr_mask & ~`AEMC_CORR_MASK_WR) == 32'h0000_0000)
		else $error("reserved mask bit stored");

	// Unmapped addresses answer with zero
	unmapped_zero_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		cfg_rd_i && !hit_mask && !hit_cap && !hit_log |=>
		cfg_rdata_o == 32'h0000_0000)
		else $error("unmapped read returned data");

	// Software fields move only on their own write
	mask_hold_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!wr_mask |=> $stable(corr_mask))
		else $error("mask changed without write");

	check_hold_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!(wr_cap && cfg_be_i[1]) |=> $stable(end_crc_check_enable_o))
		else $error("check enable changed without write");

	gen_hold_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!(wr_cap && cfg_be_i[0]) |=>
		$stable(end_crc_generate_enable_o))
		else $error("generate enable changed without write");

	// Pointer moves only on a load from the status logic
	ptr_hold_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!first_err_load_i |=> $stable(first_ptr))
		else $error("first error pointer changed by itself");

	// Log slot follows the address in doubleword steps
	log_index_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		hit_log |-> log_idx == 2'(cfg_addr_i[3:2] + 2'h1))
		else $error("log doubleword index wrong");

	// Unmasked advisory event reaches the message side
	adv_report_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		corr_err_i[5] && !corr_mask[`AEMC_MSK_ADVISORY] |=>
		corr_report_o[5])
		else $error("unmasked advisory error not reported");

	// Every event sets status, masked or not
	status_copy_a: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		1'b1 |=> corr_status_set_o == $past(corr_err_i))
		else $error("status set pulse lost");

endmodule : aemc_aer_regs

// ---- bench/aemc_cfg_host.sv ----
// Configuration software model issuing register reads and writes
module aemc_cfg_host (
	// Clock
	input wire logic core_clk_i,
	// Configuration request
	output aemc_pkg::aemc_addr_t cfg_addr_o,
	output logic cfg_rd_o,
	output logic cfg_wr_o,
	output logic [3:0] cfg_be_o,
	output aemc_pkg::aemc_dword_t cfg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial
	begin
		cfg_addr_o = 12'h000;
		cfg_rd_o = 1'b0;
		cfg_wr_o = 1'b0;
		cfg_be_o = 4'h0;
		cfg_wdata_o = 32'h0;
	end
	// One-cycle request; released lanes show the inverse of the last value
	task automatic req(input logic rd, input aemc_pkg::aemc_addr_t a,
		input logic [3:0] be, input aemc_pkg::aemc_dword_t d);
		@(negedge core_clk_i);
		cfg_addr_o = a;
		cfg_rd_o = rd;
		cfg_wr_o = ~rd;
		cfg_be_o = be;
		cfg_wdata_o = d;
		@(negedge core_clk_i);
		cfg_rd_o = 1'b0;
		cfg_wr_o = 1'b0;
		cfg_addr_o = ~a;
		cfg_be_o = ~be;
		cfg_wdata_o = ~d;
	endtask : req
endmodule : aemc_cfg_host

// ---- bench/tb.sv ----
// Self-checking bench of the error mask/control/log bank
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	aemc_pkg::aemc_addr_t cfg_addr_i;
	logic cfg_rd_i, cfg_wr_i, unc_log_i = 1'b0, first_err_load_i = 1'b0;
	logic [3:0] cfg_be_i;
	aemc_pkg::aemc_dword_t cfg_wdata_i, cfg_rdata_o;
	logic cfg_rvalid_o, chk_en_o, gen_en_o;
	logic [5:0] corr_err_i = 6'h00, corr_status_set_o, corr_report_o;
	logic [127:0] err_hdr_i = 128'h0, hdr, log_v = 128'h0;
	aemc_pkg::aemc_ptr_t first_err_pos_i = 5'h00;
	aemc_pkg::aemc_dword_t exp_q[$];
	logic [31:0] seed = 32'h52F32C19;
	int fails = 0, n_tests = 0, cyc = 0;

	aemc_aer_regs #(.NUM_CORR(6)) i_aemc_aer_regs (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i),
		.cfg_wr_i(cfg_wr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
		.cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
		.corr_err_i(corr_err_i), .unc_log_i(unc_log_i), .err_hdr_i(err_hdr_i),
		.first_err_load_i(first_err_load_i),
		.first_err_pos_i(first_err_pos_i),
		.corr_status_set_o(corr_status_set_o), .corr_report_o(corr_report_o),
		.end_crc_check_enable_o(chk_en_o),
		.end_crc_generate_enable_o(gen_en_o));
	aemc_cfg_host i_aemc_cfg_host (.core_clk_i(core_clk_i),
		.cfg_addr_o(cfg_addr_i), .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i),
		.cfg_be_o(cfg_be_i), .cfg_wdata_o(cfg_wdata_i));

	// Clock, 100 ns period
	always #50 core_clk_i = ~core_clk_i;

	// Pseudo-random source
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// Value comparison
	task automatic cmp(input string what, input logic [31:0] e,
		input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", what, e, s);
		end
	endtask : cmp

	// Read answers taken against the oldest note
	always @(negedge core_clk_i)
		if (cfg_rvalid_o === 1'b1)
		begin
			if (exp_q.size() == 0)
				cmp("unexpected rvalid", 32'h0, 32'h1);
			else
				cmp("read data", exp_q.pop_front(), cfg_rdata_o);
		end

	// Hang guard
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails++;
			test_done();
		end
	end

	task automatic rd(input aemc_pkg::aemc_addr_t a, input logic [31:0] e);
		exp_q.push_back(e);
		i_aemc_cfg_host.req(1'b1, a, 4'hF, rnd());
	endtask : rd

	task automatic wr(input aemc_pkg::aemc_addr_t a, input logic [3:0] be,
		input logic [31:0] d);
		i_aemc_cfg_host.req(1'b0, a, be, d);
	endtask : wr

	// Read back all four log doublewords
	task automatic chk_log();
		for (int i = 0; i < 4; i++)
			rd(12'h11C + 12'(4 * i), log_v[32 * i +: 32]);
	endtask : chk_log

	// One event pulse with a fresh header
	task automatic evt(input logic [5:0] e, input logic u,
		input logic [5:0] msk);
		hdr = {rnd(), rnd(), rnd(), rnd()};
		@(negedge core_clk_i);
		corr_err_i = e;
		unc_log_i = u;
		err_hdr_i = hdr;
		@(negedge core_clk_i);
		corr_err_i = 6'h00;
		unc_log_i = 1'b0;
		err_hdr_i = ~hdr;
		cmp("status set", 32'(corr_status_set_o), 32'(e));
		cmp("report", 32'(corr_report_o), 32'(e & ~msk));
		if (u || (e & ~msk) != 6'h00)
			log_v = hdr;
		chk_log();
	endtask : evt

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// Main sequence
	initial
	begin
		repeat (2) @(negedge core_clk_i);
		rst_i = 1'b0;
		rd(12'h114, 32'h0000_2000);
		rd(12'h118, 32'h0000_00A0);
		chk_log();
		rd(12'h200, 32'h0);
		wr(12'h114, 4'hF, 32'hFFFF_FFFF);
		rd(12'h114, 32'h0000_31C1);
		wr(12'h114, 4'h1, 32'h0);
		rd(12'h114, 32'h0000_3100);
		wr(12'h118, 4'hF, 32'hFFFF_FFFF);
		rd(12'h118, 32'h0000_01E0);
		cmp("check en", 32'(chk_en_o), 32'h1);
		cmp("gen en", 32'(gen_en_o), 32'h1);
		wr(12'h118, 4'h2, 32'h0);
		rd(12'h118, 32'h0000_00E0);
		cmp("check en", 32'(chk_en_o), 32'h0);
		cmp("gen en", 32'(gen_en_o), 32'h1);
		wr(12'h118, 4'hF, 32'h0);
		rd(12'h118, 32'h0000_00A0);
		@(negedge core_clk_i);
		first_err_pos_i = 5'(rnd()) | 5'h01;
		first_err_load_i = 1'b1;
		@(negedge core_clk_i);
		first_err_load_i = 1'b0;
		rd(12'h118, 32'h0000_00A0 | 32'(first_err_pos_i));
		wr(12'h114, 4'hF, 32'h0);
		for (int i = 0; i < 6; i++)
			evt(6'(1 << i), 1'b0, 6'h00);
		wr(12'h114, 4'hF, 32'hFFFF_FFFF);
		evt(6'h3F, 1'b0, 6'h3F);
		evt(6'h00, 1'b1, 6'h3F);
		wr(12'h11C, 4'hF, 32'h0);
		chk_log();
		repeat (4) @(negedge core_clk_i);
		test_done();
	end
endmodule : tb
